// ===== src/card_identity_host.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module card_identity_host (
  input wire logic mclk,
  input wire logic rst_b,
  card_identity_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import card_identity_pkg::*;
  card_identity_state_t state_reg;
  logic [2:0] idx_reg;
  logic [7:0] id_reg [0:7];
  logic present_reg;
  logic ext_reg;
  logic conform_reg;
  logic done_reg;
  logic rd_reg;
  logic [7:0] s1_reg;
  logic [7:0] s2_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [1:0] wait_reg;
  logic start;

  // write lands on the edge where the master sees ack high
  assign start = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & (wb_adr_i == CARD_IDENTITY_HR_CTRL)
    & wb_sel_i[0] & wb_dat_i[CARD_IDENTITY_CTRL_START] & (state_reg == CARD_IDENTITY_IDLE);

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= CARD_IDENTITY_IDLE_BYTE;
      s2_reg <= CARD_IDENTITY_IDLE_BYTE;
    end else begin
      s1_reg <= link.bus_level;
      s2_reg <= s1_reg;
    end
  end

  // ------------------------------------------------------------
  // probe sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= CARD_IDENTITY_IDLE;
      idx_reg <= 3'h0;
      rd_reg <= 1'b0;
      done_reg <= 1'b0;
      present_reg <= 1'b0;
      ext_reg <= 1'b0;
      conform_reg <= 1'b0;
    end else begin
      case (state_reg)
        CARD_IDENTITY_IDLE: begin
          if (start) begin
            idx_reg <= 3'h0;
            rd_reg <= 1'b1;
            done_reg <= 1'b0;
            state_reg <= CARD_IDENTITY_ADDR;
          end
        end
        CARD_IDENTITY_ADDR: begin
          if (wait_reg == CARD_IDENTITY_SETTLE_LAST) begin
            state_reg <= CARD_IDENTITY_TAKE;
          end
        end
        CARD_IDENTITY_TAKE: begin
          // wait covers card register plus two sampling stages
          if (idx_reg == 3'h0) begin
            present_reg <= ~s2_reg[CARD_IDENTITY_BIT_PRESENT];
            conform_reg <= ~s2_reg[CARD_IDENTITY_BIT_CONFORM];
            ext_reg <= ~s2_reg[CARD_IDENTITY_BIT_PRESENT] & ~s2_reg[CARD_IDENTITY_BIT_CONFORM]
              & (s2_reg[CARD_IDENTITY_TYPE_LSB +: 4] == CARD_IDENTITY_TYPE_EXT);
            if (s2_reg[CARD_IDENTITY_BIT_PRESENT] | s2_reg[CARD_IDENTITY_BIT_CONFORM]
                | (s2_reg[CARD_IDENTITY_TYPE_LSB +: 4] != CARD_IDENTITY_TYPE_EXT)) begin
              rd_reg <= 1'b0;
              done_reg <= 1'b1;
              state_reg <= CARD_IDENTITY_IDLE;
            end else begin
              idx_reg <= idx_reg + 3'h1;
              state_reg <= CARD_IDENTITY_ADDR;
            end
          end else if (idx_reg == 3'(CARD_IDENTITY_EXT_BYTES - 1)) begin
            rd_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= CARD_IDENTITY_IDLE;
          end else begin
            idx_reg <= idx_reg + 3'h1;
            state_reg <= CARD_IDENTITY_ADDR;
          end
        end
        default: state_reg <= CARD_IDENTITY_IDLE;
      endcase
    end
  end

  // settle count: a byte reaches s2_reg three edges after its address
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wait_reg <= 2'h0;
    end else if (state_reg == CARD_IDENTITY_ADDR) begin
      wait_reg <= wait_reg + 2'h1;
    end else begin
      wait_reg <= 2'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (state_reg == CARD_IDENTITY_TAKE) begin
      id_reg[idx_reg] <= s2_reg;
    end
  end

  assign link.rd = rd_reg;
  assign link.addr = card_identity_byte_addr(idx_reg);

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      dat_reg <= CARD_IDENTITY_ZERO_WORD;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      case (wb_adr_i)
        CARD_IDENTITY_HR_STAT: dat_reg <= {27'h0, done_reg, conform_reg, ext_reg, present_reg,
          (state_reg != CARD_IDENTITY_IDLE)};
        CARD_IDENTITY_HR_IDLO: dat_reg <= {id_reg[3], id_reg[2], id_reg[1], id_reg[0]};
        CARD_IDENTITY_HR_IDHI: dat_reg <= {id_reg[7], id_reg[6], id_reg[5], id_reg[4]};
        default: dat_reg <= CARD_IDENTITY_ZERO_WORD;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
endmodule

// ===== src/card_identity_pkg.sv
package card_identity_pkg;
  // ------------------------------------------------------------
  // identity layout
  // ------------------------------------------------------------
  localparam int CARD_IDENTITY_AW = 5;
  localparam logic [4:0] CARD_IDENTITY_OFS_LOW = 5'h00;
  localparam logic [4:0] CARD_IDENTITY_OFS_FLAGS = 5'h04;
  localparam logic [4:0] CARD_IDENTITY_OFS_RSVD = 5'h08;
  localparam logic [4:0] CARD_IDENTITY_OFS_PROD_LO = 5'h0C;
  localparam logic [4:0] CARD_IDENTITY_OFS_PROD_HI = 5'h10;
  localparam logic [4:0] CARD_IDENTITY_OFS_MAKER_LO = 5'h14;
  localparam logic [4:0] CARD_IDENTITY_OFS_MAKER_HI = 5'h18;
  localparam logic [4:0] CARD_IDENTITY_OFS_REGION = 5'h1C;
  localparam int CARD_IDENTITY_BIT_IRQ = 0;
  localparam int CARD_IDENTITY_BIT_PRESENT = 1;
  localparam int CARD_IDENTITY_BIT_FIQ = 2;
  localparam int CARD_IDENTITY_TYPE_LSB = 3;
  localparam int CARD_IDENTITY_BIT_CONFORM = 7;
  localparam int CARD_IDENTITY_BIT_CHUNK = 0;
  localparam int CARD_IDENTITY_BIT_MOVED = 1;
  localparam int CARD_IDENTITY_WIDTH_LSB = 2;
  localparam logic [3:0] CARD_IDENTITY_TYPE_EXT = 4'h0;
  localparam logic [1:0] CARD_IDENTITY_W8 = 2'h0;
  localparam logic [1:0] CARD_IDENTITY_W16 = 2'h1;
  localparam logic [1:0] CARD_IDENTITY_W32 = 2'h2;
  localparam logic [7:0] CARD_IDENTITY_REGION_NOW = 8'h00;
  localparam logic [7:0] CARD_IDENTITY_ZERO_BYTE = 8'h00;
  localparam logic [31:0] CARD_IDENTITY_ZERO_WORD = 32'h0000_0000;
  localparam logic [7:0] CARD_IDENTITY_IDLE_BYTE = 8'hFF;
  localparam int CARD_IDENTITY_EXT_BYTES = 8;
  // card register plus two sampling stages before a byte can be taken
  localparam logic [1:0] CARD_IDENTITY_SETTLE_LAST = 2'h2;

  // ------------------------------------------------------------
  // host controller registers (wishbone byte addresses, one word apart)
  // ------------------------------------------------------------
  localparam logic [3:0] CARD_IDENTITY_HR_CTRL = 4'h0;
  localparam logic [3:0] CARD_IDENTITY_HR_STAT = 4'h4;
  localparam logic [3:0] CARD_IDENTITY_HR_IDLO = 4'h8;
  localparam logic [3:0] CARD_IDENTITY_HR_IDHI = 4'hC;
  localparam int CARD_IDENTITY_CTRL_START = 0;
  localparam int CARD_IDENTITY_ST_BUSY = 0;
  localparam int CARD_IDENTITY_ST_PRESENT = 1;
  localparam int CARD_IDENTITY_ST_EXT = 2;
  localparam int CARD_IDENTITY_ST_CONFORM = 3;
  localparam int CARD_IDENTITY_ST_DONE = 4;

  typedef enum logic [1:0] {
    CARD_IDENTITY_IDLE = 2'b00,
    CARD_IDENTITY_ADDR = 2'b01,
    CARD_IDENTITY_TAKE = 2'b11
  } card_identity_state_t;

  function automatic logic [4:0] card_identity_byte_addr(input logic [2:0] idx);
    card_identity_byte_addr = {idx, 2'b00};
  endfunction
endpackage

// ===== src/card_identity_if.sv
`timescale 1ns/1ps
interface card_identity_if;
  import card_identity_pkg::*;
  logic rd;
  logic [CARD_IDENTITY_AW-1:0] addr;
  logic [7:0] card_data;
  logic card_oe;
  logic [7:0] bus_level;
  logic normal_irq_line_n;
  logic fast_irq_line_n;
  // pull-up on every data bit, so an empty slot reads ones
  assign bus_level = card_oe ? card_data : CARD_IDENTITY_IDLE_BYTE;
  modport card (
    input rd,
    input addr,
    output card_data,
    output card_oe,
    output normal_irq_line_n,
    output fast_irq_line_n
  );
  modport host (
    output rd,
    output addr,
    input bus_level,
    input normal_irq_line_n,
    input fast_irq_line_n
  );
endinterface

// ===== src/card_identity_byte_mux.sv
`timescale 1ns/1ps
module card_identity_byte_mux (
  input wire logic [card_identity_pkg::CARD_IDENTITY_AW-1:0] addr,
  input wire logic irq_pending,
  input wire logic fiq_pending,
  input wire logic status_moved,
  input wire logic chunk_list_follows,
  input wire logic [1:0] width_code,
  input wire logic [3:0] simple_type_field,
  input wire logic non_conform,
  input wire logic [15:0] product_code,
  input wire logic [15:0] maker_code,
  output logic [7:0] data
);
  import card_identity_pkg::*;
  logic [7:0] low_byte;
  logic [7:0] flag_byte;

  always_comb begin
    low_byte = CARD_IDENTITY_ZERO_BYTE;
    low_byte[CARD_IDENTITY_BIT_IRQ] = irq_pending & ~status_moved;
    low_byte[CARD_IDENTITY_BIT_FIQ] = fiq_pending & ~status_moved;
    low_byte[CARD_IDENTITY_BIT_PRESENT] = 1'b0;
    low_byte[CARD_IDENTITY_TYPE_LSB +: 4] = simple_type_field;
    low_byte[CARD_IDENTITY_BIT_CONFORM] = non_conform;
  end

  always_comb begin
    flag_byte = CARD_IDENTITY_ZERO_BYTE;
    flag_byte[CARD_IDENTITY_BIT_CHUNK] = chunk_list_follows;
    flag_byte[CARD_IDENTITY_BIT_MOVED] = status_moved;
    flag_byte[CARD_IDENTITY_WIDTH_LSB +: 2] = width_code;
  end

  always_comb begin
    case (addr)
      CARD_IDENTITY_OFS_LOW: data = low_byte;
      CARD_IDENTITY_OFS_FLAGS: data = flag_byte;
      CARD_IDENTITY_OFS_RSVD: data = CARD_IDENTITY_ZERO_BYTE;
      CARD_IDENTITY_OFS_PROD_LO: data = product_code[7:0];
      CARD_IDENTITY_OFS_PROD_HI: data = product_code[15:8];
      CARD_IDENTITY_OFS_MAKER_LO: data = maker_code[7:0];
      CARD_IDENTITY_OFS_MAKER_HI: data = maker_code[15:8];
      CARD_IDENTITY_OFS_REGION: data = CARD_IDENTITY_REGION_NOW;
      default: data = CARD_IDENTITY_ZERO_BYTE;
    endcase
  end
endmodule

// ===== src/card_identity_card.sv
`timescale 1ns/1ps
// Notes on behaviour
// - irq line low sets low-byte bit 0
// - fiq line low sets low-byte bit 2
// - card drives bit 1 low: present
// - host pull-up; bit 1 high means empty
// - bits 3-6 type; zero means extended identity
// - extended identity cards return zero type
// - bit 7 zero conforms; host ignores otherwise
// - no interrupt source: bits 0, 2 zero
// - separate status bit per interrupt type
// - relocated status: bits 0, 2 zero
// - relocated pointers sit above extended identity
// - unsupported type gets all-zero position mask
// - host reads seven more identity bytes
// - identity starts address 0, low byte first
// - byte 1 bit 0: chunk list follows
// - byte 1 bit 1: status relocated
// - byte 1 bits 3:2 give width code
// - reserved bits of bytes 1, 2 zero
// - identity mapped at zero after reset
// - region byte reads 00
module card_identity_card #(
  parameter logic [15:0] PRODUCT_CODE = 16'h0001, // arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'h0001, // arbitrary value
  parameter logic [3:0] SIMPLE_TYPE = 4'h0,
  parameter logic [1:0] WIDTH_CODE = 2'h0,
  parameter logic HAS_IRQ = 1'b1,
  parameter logic HAS_FIQ = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  card_identity_if.card link,
  input wire logic irq_req,
  input wire logic fiq_req,
  output logic irq_status,
  output logic fiq_status
);
  import card_identity_pkg::*;
  logic irq_reg;
  logic fiq_reg;
  logic oe_reg;
  logic [7:0] data_reg;
  logic [7:0] data_next;

  // ------------------------------------------------------------
  // interrupt sources
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_req & HAS_IRQ;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fiq_reg <= 1'b0;
    end else begin
      fiq_reg <= fiq_req & HAS_FIQ;
    end
  end

  assign link.normal_irq_line_n = ~irq_reg;
  assign link.fast_irq_line_n = ~fiq_reg;
  assign irq_status = irq_reg;
  assign fiq_status = fiq_reg;

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // pointers for relocated status are not held here, so status stays in byte 0
  card_identity_byte_mux u_mux (
    .addr(link.addr),
    .irq_pending(irq_reg),
    .fiq_pending(fiq_reg),
    .status_moved(1'b0),
    .chunk_list_follows(1'b0),
    .width_code(WIDTH_CODE),
    .simple_type_field(SIMPLE_TYPE),
    .non_conform(1'b0),
    .product_code(PRODUCT_CODE),
    .maker_code(MAKER_CODE),
    .data(data_next)
  );

  // read is pure lookup, no state touched
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      data_reg <= CARD_IDENTITY_ZERO_BYTE;
      oe_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      oe_reg <= link.rd;
    end
  end

  assign link.card_data = data_reg;
  assign link.card_oe = oe_reg;
endmodule

// ===== tb/card_identity_checker.sv
`timescale 1ns/1ps
module card_identity_checker #(
  parameter logic [15:0] PRODUCT_CODE = 16'h0001,
  parameter logic [15:0] MAKER_CODE = 16'h0001,
  parameter logic [1:0] WIDTH_CODE = 2'h0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic rd,
  input wire logic [card_identity_pkg::CARD_IDENTITY_AW-1:0] addr,
  input wire logic [7:0] card_data,
  input wire logic card_oe,
  input wire logic [7:0] bus_level,
  input wire logic normal_irq_line_n,
  input wire logic fast_irq_line_n
);
  import card_identity_pkg::*;
  logic [CARD_IDENTITY_AW-1:0] addr_q;
  logic [7:0] exp_byte;
  logic fixed;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // card_data shows the byte for the address seen one edge earlier
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= 5'h00;
    end else begin
      addr_q <= addr;
    end
  end
  always_comb begin
    fixed = 1'b1;
    exp_byte = 8'h00;
    case (addr_q)
      CARD_IDENTITY_OFS_PROD_LO: exp_byte = PRODUCT_CODE[7:0];
      CARD_IDENTITY_OFS_PROD_HI: exp_byte = PRODUCT_CODE[15:8];
      CARD_IDENTITY_OFS_MAKER_LO: exp_byte = MAKER_CODE[7:0];
      CARD_IDENTITY_OFS_MAKER_HI: exp_byte = MAKER_CODE[15:8];
      CARD_IDENTITY_OFS_RSVD, CARD_IDENTITY_OFS_REGION: exp_byte = 8'h00;
      default: fixed = 1'b0;
    endcase
  end
  // ------------------------------------------------------------
  // low byte
  // ------------------------------------------------------------
  // line held two edges, so either sampling point of the card agrees
  chk_irq_set: assert property (card_oe && addr_q == CARD_IDENTITY_OFS_LOW && !normal_irq_line_n && $past(!normal_irq_line_n) |-> card_data[0]) else $error("irq status bit clear");
  chk_irq_clear: assert property (card_oe && addr_q == CARD_IDENTITY_OFS_LOW && normal_irq_line_n && $past(normal_irq_line_n) |-> !card_data[0]) else $error("irq status bit set");
  chk_fiq_set: assert property (card_oe && addr_q == CARD_IDENTITY_OFS_LOW && !fast_irq_line_n && $past(!fast_irq_line_n) |-> card_data[2]) else $error("fiq status bit clear");
  chk_fiq_clear: assert property (card_oe && addr_q == CARD_IDENTITY_OFS_LOW && fast_irq_line_n && $past(fast_irq_line_n) |-> !card_data[2]) else $error("fiq status bit set");
  chk_present_low: assert property (card_oe && addr_q == CARD_IDENTITY_OFS_LOW |-> card_data[1] == 1'b0) else $error("present bit high");
  chk_type_conform: assert property (card_oe && addr_q == CARD_IDENTITY_OFS_LOW |-> card_data[7:3] == 5'h00) else $error("type or conform bits set");
  // ------------------------------------------------------------
  // extended bytes and drive
  // ------------------------------------------------------------
  chk_flags_byte: assert property (card_oe && addr_q == CARD_IDENTITY_OFS_FLAGS |-> card_data == {4'h0, WIDTH_CODE, 2'b00}) else $error("flags byte wrong");
  chk_fixed_bytes: assert property (card_oe && fixed |-> card_data == exp_byte) else $error("identity byte wrong");
  chk_oe_on: assert property ($rose(rd) |=> card_oe) else $error("card not driving on read");
  chk_oe_off: assert property ($fell(rd) |=> !card_oe ##1 !card_oe || rd) else $error("card drives when idle");
  chk_bus_pullup: assert property (!card_oe |-> bus_level == CARD_IDENTITY_IDLE_BYTE) else $error("idle bus not pulled high");
endmodule

// ===== tb/expansion_card_identity_test.sv
`timescale 1ns/1ps
module expansion_card_identity_test;
  import card_identity_pkg::*;
  localparam logic [15:0] PROD = 16'h1234;
  localparam logic [15:0] MAKR = 16'h0BCD; // arbitrary value
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic irq_req = 1'b0;
  logic fiq_req = 1'b0;
  logic [1:0] cyc = 2'b00;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  wire logic [1:0] ack;
  wire logic [31:0] rdat0;
  wire logic [31:0] rdat1;
  logic irq_status;
  logic fiq_status;
  logic [31:0] q;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int i;
  card_identity_if link();
  card_identity_if empty();
  // second slot has no card: bus floats to the pull-up
  assign empty.card_oe = 1'b0;
  assign empty.card_data = 8'h00;
  assign empty.normal_irq_line_n = 1'b1;
  assign empty.fast_irq_line_n = 1'b1;
  always #10 mclk = ~mclk;
  card_identity_card #(.PRODUCT_CODE(PROD), .MAKER_CODE(MAKR), .WIDTH_CODE(CARD_IDENTITY_W32)) u_card_identity_card (.mclk(mclk),
    .rst_b(rst_b), .link(link), .irq_req(irq_req), .fiq_req(fiq_req), .irq_status(irq_status),
    .fiq_status(fiq_status));
  card_identity_host u_card_identity_host (.mclk(mclk), .rst_b(rst_b), .link(link), .wb_cyc_i(cyc[0]), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat0), .wb_ack_o(ack[0]));
  card_identity_host u_card_identity_host_empty (.mclk(mclk), .rst_b(rst_b), .link(empty), .wb_cyc_i(cyc[1]), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat1), .wb_ack_o(ack[1]));
  card_identity_checker #(.PRODUCT_CODE(PROD), .MAKER_CODE(MAKR), .WIDTH_CODE(CARD_IDENTITY_W32)) u_card_identity_checker (.mclk(mclk),
    .rst_b(rst_b), .rd(link.rd), .addr(link.addr), .card_data(link.card_data), .card_oe(link.card_oe),
    .bus_level(link.bus_level), .normal_irq_line_n(link.normal_irq_line_n),
    .fast_irq_line_n(link.fast_irq_line_n));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("mismatches=%0d checks=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input int k, input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc[k] <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge mclk);
    end while (ack[k] !== 1'b1);
    q = k ? rdat1 : rdat0;
    cyc[k] <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic probe(input int k);
    int n;
    n = 0;
    wb(k, 1'b1, CARD_IDENTITY_HR_CTRL, 32'h0000_0001);
    q = 32'h0000_0001;
    while (!(q[CARD_IDENTITY_ST_BUSY] === 1'b0 && q[CARD_IDENTITY_ST_DONE] === 1'b1) && n < 100) begin
      wb(k, 1'b0, CARD_IDENTITY_HR_STAT, 32'h0000_0000);
      n++;
    end
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 4; i++) begin
      irq_req <= i[0];
      fiq_req <= i[1];
      repeat (4) @(posedge mclk);
      chk({30'h0, fiq_status, irq_status}, {30'h0, i[1:0]});
      probe(0);
      chk(q[4:0], 5'h1E);
      wb(0, 1'b0, CARD_IDENTITY_HR_IDLO, 32'h0000_0000);
      chk(q, {PROD[7:0], 8'h00, 8'h08, 5'h00, i[1], 1'b0, i[0]});
      wb(0, 1'b0, CARD_IDENTITY_HR_IDHI, 32'h0000_0000);
      chk(q, {8'h00, MAKR, PROD[15:8]});
    end
    wb(0, 1'b0, 4'h2, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    probe(1);
    chk({27'h0, q[4:0]}, 32'h0000_0010);
    end_sim();
  end
endmodule
